// *** core/ifmsc_ctrl.sv ***
// Interrupt flags, masks, vectoring and sleep control with APB registers
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [R1] Pin one event sets flag, vector 2
// [R2] Pin zero event sets flag, vector 1
// [R3] Flags clear on vectoring or write-one
// [R4] Sixteen-bit overflow sets flag, vector 5
// [R5] PWM overflow flag at reversal at zero
// [R6] Compare match sets flag, vector 4
// [R7] Capture copies count, sets flag, vector 3
// [R8] Eight-bit overflow sets flag, vector 6
// [R9] Taken only with global, mask, flag; in level mode the code uses a low pin in place of the flag
// [R10] Pin interrupts fire even as outputs
// [R11] Level mode requests while pin low
// [R12] Entry four cycles, push two bytes
// [R13] Vector jump takes two cycles
// [R14] Finish current instruction before entry
// [R15] Return four cycles, pop two bytes
// [R16] One instruction after return before next; code waits for two instruction ends
// [R17] Status word saved by software only
// [R18] Persistent conditions flag only on occurrence
// [R19] Sleep only when sleep_allow set
// [R20] deep_sleep_select picks idle or power-down
// [R21] Sense fields per pin, gated by enables
// [R22] Reserved bits read zero, ignore writes
// [R23] Sense codes: low, any, fall, rise
// [R24] Level mode leaves flag clear, still requests
// [R25] Pin enables at mask bits 7, 6
// [R26] Entry clears the global enable
// [R27] Lowest vector wins among pending
module ifmsc_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ifmsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_pin_a,
  input wire logic ext_pin_b,
  input wire logic capture_input_pin,
  input wire ifmsc_pkg::ifmsc_tmr_t tmr_i,
  input wire logic instr_done,
  input wire logic reti_req,
  input wire logic doze_instr,
  output ifmsc_pkg::ifmsc_cpu_t cpu_o,
  output logic sleep_enter,
  output logic sleep_deep
);
  logic [7:0] mcu_control_r;
  logic [7:0] timer_irq_flags_r;
  logic [7:0] timer_irq_mask_r;
  logic [7:0] external_irq_flags_r;
  logic [7:0] external_irq_mask_r;
  logic [7:0] gie_r;
  logic [15:0] cmp_value_r;
  logic [15:0] capture_value_r;
  logic [2:0] sy1_r;
  logic [2:0] sy2_r;
  logic [2:0] prev_r;
  logic down_prev_r;
  logic eq_prev_r;
  logic [31:0] prdata_r;
  logic sleep_enter_r;
  logic sleep_deep_r;
  ifmsc_pkg::ifmsc_state_t state_r;
  logic [2:0] cnt_r;
  logic [2:0] vec_r;
  logic [5:0] idx;
  logic hit;
  logic wr;
  logic [7:0] wb;
  logic [7:0] rdv;
  logic pin_a;
  logic pin_b;
  logic cap_pin;
  logic ev_a;
  logic ev_b;
  logic lvl_a;
  logic lvl_b;
  logic eq;
  logic t1_set;
  logic cmp_set;
  logic cap_set;
  logic [7:0] tset;
  logic [7:0] xset;
  logic [7:0] tclr;
  logic [7:0] xclr;
  logic [5:0] req;
  logic [2:0] sel;
  logic any_req;
  logic gie;
  logic vec_clr;
  logic ent_go;

  // APB decode
  assign idx = paddr[7:2];
  assign wr = psel && penable && pwrite;
  assign wb = pwdata[7:0];
  assign pready = 1'b1;
  always_comb
  begin
    hit = 1'b1;
    rdv = 8'h00;
    case (idx)
      ifmsc_pkg::IDX_MCU: rdv = mcu_control_r;
      ifmsc_pkg::IDX_TFLG: rdv = timer_irq_flags_r;
      ifmsc_pkg::IDX_TMSK: rdv = timer_irq_mask_r;
      ifmsc_pkg::IDX_XFLG: rdv = external_irq_flags_r;
      ifmsc_pkg::IDX_XMSK: rdv = external_irq_mask_r;
      ifmsc_pkg::IDX_GIE: rdv = gie_r;
      ifmsc_pkg::IDX_CMP_LO: rdv = cmp_value_r[7:0];
      ifmsc_pkg::IDX_CMP_HI: rdv = cmp_value_r[15:8];
      ifmsc_pkg::IDX_CAP_LO: rdv = capture_value_r[7:0];
      ifmsc_pkg::IDX_CAP_HI: rdv = capture_value_r[15:8];
      default: hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_r;

  // Read data is captured in the setup cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_r <= {24'h00_0000, rdv};
  end

  // [R22] reserved bits masked
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mcu_control_r <= ifmsc_pkg::RST_VAL;
      timer_irq_mask_r <= ifmsc_pkg::RST_VAL;
      external_irq_mask_r <= ifmsc_pkg::RST_VAL;
      cmp_value_r <= 16'h0000;
    end
    else if (wr)
    begin
      case (idx)
        ifmsc_pkg::IDX_MCU: mcu_control_r <= wb & ifmsc_pkg::MCU_MASK;
        ifmsc_pkg::IDX_TMSK: timer_irq_mask_r <= wb & ifmsc_pkg::TMR_MASK;
        ifmsc_pkg::IDX_XMSK: external_irq_mask_r <= wb & ifmsc_pkg::EXT_MASK;
        ifmsc_pkg::IDX_CMP_LO: cmp_value_r[7:0] <= wb;
        ifmsc_pkg::IDX_CMP_HI: cmp_value_r[15:8] <= wb;
        default: cmp_value_r <= cmp_value_r;
      endcase
    end
  end

  // [R26] entry clears global enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gie_r <= ifmsc_pkg::RST_VAL;
    else if (ent_go)
      gie_r <= 8'h00;
    else if (wr && idx == ifmsc_pkg::IDX_GIE)
      gie_r <= wb & ifmsc_pkg::GIE_MASK;
  end
  assign gie = gie_r[ifmsc_pkg::B_GIE];

  // Pin synchronisers and edge history
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sy1_r <= 3'h7;
      sy2_r <= 3'h7;
      prev_r <= 3'h7;
    end
    else
    begin
      sy1_r <= {capture_input_pin, ext_pin_b, ext_pin_a};
      sy2_r <= sy1_r;
      prev_r <= sy2_r;
    end
  end
  assign pin_a = sy2_r[0];
  assign pin_b = sy2_r[1];
  assign cap_pin = sy2_r[2];

  // [R23] sense decode per pin
  function automatic logic sense_evt(input logic [1:0] mode,
                                     input logic now,
                                     input logic was);
    case (mode)
      ifmsc_pkg::SNS_ANY: sense_evt = now ^ was;
      ifmsc_pkg::SNS_FALL: sense_evt = was && !now;
      ifmsc_pkg::SNS_RISE: sense_evt = now && !was;
      default: sense_evt = 1'b0;
    endcase
  endfunction

  // [R21] fields at bits 3:2 and 1:0
  assign ev_a = sense_evt(mcu_control_r[ifmsc_pkg::B_SNS_A +: 2], pin_a,
                          prev_r[0]);
  assign ev_b = sense_evt(mcu_control_r[ifmsc_pkg::B_SNS_B +: 2], pin_b,
                          prev_r[1]);
  assign lvl_a = mcu_control_r[ifmsc_pkg::B_SNS_A +: 2] == ifmsc_pkg::SNS_LOW;
  assign lvl_b = mcu_control_r[ifmsc_pkg::B_SNS_B +: 2] == ifmsc_pkg::SNS_LOW;

  // [R5] PWM overflow at reversal at zero
  assign t1_set = tmr_i.t1_pwm ?
    (down_prev_r && !tmr_i.t1_down && tmr_i.t1_count == 16'h0000) :
    tmr_i.t1_wrap;
  assign eq = tmr_i.t1_count == cmp_value_r;
  // [R18] compare flags on the match edge only
  assign cmp_set = eq && !eq_prev_r;
  assign cap_set = cap_pin && !prev_r[2];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      down_prev_r <= 1'b0;
      eq_prev_r <= 1'b0;
    end
    else
    begin
      down_prev_r <= tmr_i.t1_down;
      eq_prev_r <= eq;
    end
  end

  // [R7] capture copies the counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      capture_value_r <= 16'h0000;
    else if (cap_set)
      capture_value_r <= tmr_i.t1_count;
  end

  // Set and clear vectors for the flag registers
  always_comb
  begin
    tset = 8'h00;
    xset = 8'h00;
    tclr = 8'h00;
    xclr = 8'h00;
    // [R4] sixteen-bit overflow flag
    tset[ifmsc_pkg::B_T1_OVF] = t1_set;
    // [R6] compare match flag
    tset[ifmsc_pkg::B_CMP] = cmp_set;
    tset[ifmsc_pkg::B_CAP] = cap_set;
    // [R8] eight-bit overflow flag
    tset[ifmsc_pkg::B_T0_OVF] = tmr_i.t0_ovf;
    // [R24] level mode sets no flag
    // [R2] pin zero event flag
    xset[ifmsc_pkg::B_EXT_A] = ev_a && !lvl_a;
    // [R1] pin one event flag
    xset[ifmsc_pkg::B_EXT_B] = ev_b && !lvl_b;
    if (wr && idx == ifmsc_pkg::IDX_TFLG)
      tclr = wb;
    if (wr && idx == ifmsc_pkg::IDX_XFLG)
      xclr = wb;
    if (vec_clr)
    begin
      case (vec_r)
        3'h1: xclr[ifmsc_pkg::B_EXT_A] = 1'b1;
        3'h2: xclr[ifmsc_pkg::B_EXT_B] = 1'b1;
        3'h3: tclr[ifmsc_pkg::B_CAP] = 1'b1;
        3'h4: tclr[ifmsc_pkg::B_CMP] = 1'b1;
        3'h5: tclr[ifmsc_pkg::B_T1_OVF] = 1'b1;
        3'h6: tclr[ifmsc_pkg::B_T0_OVF] = 1'b1;
        default: tclr = tclr;
      endcase
    end
  end

  // [R3] write-one or vectoring clears, set wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer_irq_flags_r <= ifmsc_pkg::RST_VAL;
      external_irq_flags_r <= ifmsc_pkg::RST_VAL;
    end
    else
    begin
      timer_irq_flags_r <= ((timer_irq_flags_r & ~tclr) | tset) &
                           ifmsc_pkg::TMR_MASK;
      external_irq_flags_r <= ((external_irq_flags_r & ~xclr) | xset) &
                              ifmsc_pkg::EXT_MASK;
    end
  end

  // [R25] pin enables at mask bits 7, 6
  // [R9] request needs global, mask and flag; in level mode a low pin stands in for the flag
  // [R11] level mode requests while pin low
  // [R10] pin level seen whatever its direction
  assign req[0] = gie && external_irq_mask_r[ifmsc_pkg::B_EXT_A] &&
    (lvl_a ? !pin_a : external_irq_flags_r[ifmsc_pkg::B_EXT_A]);
  assign req[1] = gie && external_irq_mask_r[ifmsc_pkg::B_EXT_B] &&
    (lvl_b ? !pin_b : external_irq_flags_r[ifmsc_pkg::B_EXT_B]);
  assign req[2] = gie && timer_irq_mask_r[ifmsc_pkg::B_CAP] &&
    timer_irq_flags_r[ifmsc_pkg::B_CAP];
  assign req[3] = gie && timer_irq_mask_r[ifmsc_pkg::B_CMP] &&
    timer_irq_flags_r[ifmsc_pkg::B_CMP];
  assign req[4] = gie && timer_irq_mask_r[ifmsc_pkg::B_T1_OVF] &&
    timer_irq_flags_r[ifmsc_pkg::B_T1_OVF];
  assign req[5] = gie && timer_irq_mask_r[ifmsc_pkg::B_T0_OVF] &&
    timer_irq_flags_r[ifmsc_pkg::B_T0_OVF];
  assign any_req = |req;

  // [R27] lowest vector first
  always_comb
  begin
    sel = 3'h0;
    for (int i = ifmsc_pkg::NSRC - 1; i >= 0; i--)
      if (req[i])
        sel = 3'(i + 1);
  end

  // [R14] entry only at an instruction boundary
  assign ent_go = state_r == ifmsc_pkg::IFMSC_RUN && any_req && instr_done;
  assign vec_clr = state_r == ifmsc_pkg::IFMSC_ENT &&
                   cnt_r == ifmsc_pkg::ENTRY_CYC - 3'h1;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ifmsc_pkg::IFMSC_RUN;
      cnt_r <= 3'h0;
      vec_r <= 3'h0;
    end
    else
    begin
      cnt_r <= cnt_r + 3'h1;
      case (state_r)
        ifmsc_pkg::IFMSC_RUN:
        begin
          cnt_r <= 3'h0;
          if (ent_go)
          begin
            state_r <= ifmsc_pkg::IFMSC_ENT;
            vec_r <= sel;
          end
          else if (reti_req)
            state_r <= ifmsc_pkg::IFMSC_RET;
        end
        // [R12] four entry cycles
        ifmsc_pkg::IFMSC_ENT:
          if (vec_clr)
          begin
            state_r <= ifmsc_pkg::IFMSC_JMP;
            cnt_r <= 3'h0;
          end
        // [R13] two cycles for the vector jump
        ifmsc_pkg::IFMSC_JMP:
          if (cnt_r == ifmsc_pkg::JUMP_CYC - 3'h1)
            state_r <= ifmsc_pkg::IFMSC_RUN;
        // [R15] four return cycles
        ifmsc_pkg::IFMSC_RET:
          if (cnt_r == ifmsc_pkg::RET_CYC - 3'h1)
            state_r <= ifmsc_pkg::IFMSC_HOLD;
        // [R16] one instruction required; hold then boundary let two end before the next entry
        ifmsc_pkg::IFMSC_HOLD:
          if (instr_done)
            state_r <= ifmsc_pkg::IFMSC_RUN;
        default: state_r <= ifmsc_pkg::IFMSC_RUN;
      endcase
    end
  end

  // Commands to the stack logic; status word is left alone
  always_comb
  begin
    cpu_o = '0;
    cpu_o.entry = state_r == ifmsc_pkg::IFMSC_ENT;
    cpu_o.push = cpu_o.entry && cnt_r < ifmsc_pkg::PC_BYTES;
    cpu_o.sp_dec = cpu_o.push;
    cpu_o.jump = state_r == ifmsc_pkg::IFMSC_JMP;
    cpu_o.ret = state_r == ifmsc_pkg::IFMSC_RET;
    cpu_o.pop = cpu_o.ret && cnt_r < ifmsc_pkg::PC_BYTES;
    cpu_o.sp_inc = cpu_o.pop;
    cpu_o.vec_addr = {9'h000, vec_r};
  end

  // [R19] sleep gated by sleep_allow
  // [R20] mode bit picks the sleep kind
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_enter_r <= 1'b0;
      sleep_deep_r <= 1'b0;
    end
    else
    begin
      sleep_enter_r <= doze_instr &&
                       mcu_control_r[ifmsc_pkg::B_SLEEP_ALLOW];
      sleep_deep_r <= mcu_control_r[ifmsc_pkg::B_DEEP_SLEEP];
    end
  end
  assign sleep_enter = sleep_enter_r;
  assign sleep_deep = sleep_deep_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_entry;
    (state_r == ifmsc_pkg::IFMSC_ENT)[*4] ##1
    (state_r == ifmsc_pkg::IFMSC_JMP)[*2];
  endsequence
  sequence s_return;
    (state_r == ifmsc_pkg::IFMSC_RET)[*4] ##1
    state_r == ifmsc_pkg::IFMSC_HOLD;
  endsequence

  a_entry_len: // [R12]
    assert property ($rose(cpu_o.entry) |-> s_entry ##1
                     state_r == ifmsc_pkg::IFMSC_RUN)
    else $error("entry or jump length wrong");
  a_return_len: // [R15]
    assert property ($rose(cpu_o.ret) |-> s_return)
    else $error("return length wrong");
  a_hold_wait: // [R16]
    assert property (state_r == ifmsc_pkg::IFMSC_HOLD && !instr_done
                     |=> state_r == ifmsc_pkg::IFMSC_HOLD)
    else $error("left hold without an instruction");
  a_entry_boundary: // [R14]
    assert property ($rose(cpu_o.entry) |-> $past(instr_done))
    else $error("entry without instruction boundary");
  a_gie_cleared: // [R26]
    assert property ($rose(cpu_o.entry) |-> !gie)
    else $error("global enable not cleared on entry");
  a_sleep_gate: // [R19]
    assert property (sleep_enter |->
      $past(doze_instr && mcu_control_r[ifmsc_pkg::B_SLEEP_ALLOW]))
    else $error("sleep without permission");
  a_reserved_zero: // [R22]
    assert property ((timer_irq_flags_r & ~ifmsc_pkg::TMR_MASK) == 8'h00 &&
      (mcu_control_r & ~ifmsc_pkg::MCU_MASK) == 8'h00)
    else $error("reserved bit set");
  a_cmp_edge: // [R18]
    assert property (eq && $past(eq) && !timer_irq_flags_r[6]
                     |=> !timer_irq_flags_r[6])
    else $error("compare flag set by standing match");
  a_vec_lowest: // [R27]
    assert property (ent_go |=> vec_r == $past(sel) && vec_r != 3'h0)
    else $error("wrong vector taken");
  a_flag_wclr: // [R3]
    assert property (wr && idx == ifmsc_pkg::IDX_TFLG && wb[1] &&
                     !tmr_i.t0_ovf |=> !timer_irq_flags_r[1])
    else $error("write one did not clear flag");
endmodule

`default_nettype wire

// *** core/ifmsc_pkg.sv ***
// Constants, states and carrier types of the interrupt flag and mask block
package ifmsc_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MCU = 6'h35;
  localparam logic [5:0] IDX_TFLG = 6'h38;
  localparam logic [5:0] IDX_TMSK = 6'h39;
  localparam logic [5:0] IDX_XFLG = 6'h3a;
  localparam logic [5:0] IDX_XMSK = 6'h3b;
  localparam logic [5:0] IDX_GIE = 6'h3f;
  localparam logic [5:0] IDX_CMP_LO = 6'h2a;
  localparam logic [5:0] IDX_CMP_HI = 6'h2b;
  localparam logic [5:0] IDX_CAP_LO = 6'h26;
  localparam logic [5:0] IDX_CAP_HI = 6'h27;
  // Writable bits of each register
  localparam logic [7:0] MCU_MASK = 8'h3f;
  localparam logic [7:0] TMR_MASK = 8'hca;
  localparam logic [7:0] EXT_MASK = 8'hc0;
  localparam logic [7:0] GIE_MASK = 8'h80;
  localparam logic [7:0] RST_VAL = 8'h00;
  // Bit positions
  localparam int unsigned B_EXT_B = 7;
  localparam int unsigned B_EXT_A = 6;
  localparam int unsigned B_T1_OVF = 7;
  localparam int unsigned B_CMP = 6;
  localparam int unsigned B_CAP = 3;
  localparam int unsigned B_T0_OVF = 1;
  localparam int unsigned B_SLEEP_ALLOW = 5;
  localparam int unsigned B_DEEP_SLEEP = 4;
  localparam int unsigned B_SNS_B = 2;
  localparam int unsigned B_SNS_A = 0;
  localparam int unsigned B_GIE = 7;
  // Sense field encodings
  localparam logic [1:0] SNS_LOW = 2'h0;
  localparam logic [1:0] SNS_ANY = 2'h1;
  localparam logic [1:0] SNS_FALL = 2'h2;
  localparam logic [1:0] SNS_RISE = 2'h3;
  // Sequencing lengths in clock cycles, stacked bytes and the source count
  localparam logic [2:0] ENTRY_CYC = 3'h4;
  localparam logic [2:0] JUMP_CYC = 3'h2;
  localparam logic [2:0] RET_CYC = 3'h4;
  localparam logic [2:0] PC_BYTES = 3'h2;
  localparam int unsigned NSRC = 6;
  typedef enum logic [2:0] {
    IFMSC_RUN = 3'h0,
    IFMSC_ENT = 3'h1,
    IFMSC_JMP = 3'h3,
    IFMSC_RET = 3'h4,
    IFMSC_HOLD = 3'h6
  } ifmsc_state_t;
  // Timer events from the counters outside
  typedef struct packed {
    logic t1_wrap;
    logic t1_pwm;
    logic t1_down;
    logic [15:0] t1_count;
    logic t0_ovf;
  } ifmsc_tmr_t;
  // Sequencing commands to the program counter and stack logic
  typedef struct packed {
    logic entry;
    logic push;
    logic sp_dec;
    logic jump;
    logic ret;
    logic pop;
    logic sp_inc;
    logic [11:0] vec_addr;
  } ifmsc_cpu_t;
endpackage

// *** tb/ifmsc_core_model.sv ***
// Core-side model: instruction boundaries and stack pointer
`timescale 1ns/10ps
`default_nettype none
module ifmsc_core_model (
  input wire logic clk,
  input wire logic rst,
  input wire ifmsc_pkg::ifmsc_cpu_t cpu_o,
  input wire logic [1:0] ilen,
  input wire logic stall,
  output logic instr_done,
  output logic [7:0] sp_r
);
  logic [1:0] cnt_r;
  logic busy;
  assign busy = cpu_o.entry | cpu_o.jump | cpu_o.ret;
  // instructions last ilen plus one cycles
  assign instr_done = !busy && !stall && cnt_r == ilen;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_r <= 2'h0;
    else if (busy || stall || cnt_r == ilen)
      cnt_r <= 2'h0;
    else
      cnt_r <= cnt_r + 2'h1;
  end
  // one stack byte per push or pop cycle
  // only the program counter is stacked
  // Handler software saves the status word itself
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sp_r <= 8'hff;
    else if (cpu_o.push && cpu_o.sp_dec)
      sp_r <= sp_r - 8'h1;
    else if (cpu_o.pop && cpu_o.sp_inc)
      sp_r <= sp_r + 8'h1;
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the interrupt flag and mask block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_a = 1'h1;
  logic pin_b = 1'h1;
  logic cap_pin = 1'h0;
  ifmsc_pkg::ifmsc_tmr_t tmr = {3'h0, 16'hffff, 1'h0};
  logic instr_done;
  logic reti_req = 1'h0;
  logic doze = 1'h0;
  ifmsc_pkg::ifmsc_cpu_t cpu;
  logic sleep_enter;
  logic sleep_deep;
  logic [1:0] ilen = 2'h0;
  logic stall = 1'h0;
  logic [7:0] sp;
  logic [7:0] q;
  logic err;
  logic done_q = 1'h0;
  logic ent_q = 1'h0;
  int err_count = 0;
  int checks_done = 0;

  always #2.5 clk = ~clk;

  ifmsc_ctrl dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_pin_a(pin_a),
    .ext_pin_b(pin_b), .capture_input_pin(cap_pin), .tmr_i(tmr),
    .instr_done(instr_done), .reti_req(reti_req), .doze_instr(doze),
    .cpu_o(cpu), .sleep_enter(sleep_enter), .sleep_deep(sleep_deep));
  ifmsc_core_model core (.clk(clk), .rst(rst), .cpu_o(cpu), .ilen(ilen),
    .stall(stall), .instr_done(instr_done), .sp_r(sp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic [5:0] ix, input logic w, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1)
      @(posedge clk);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    apb(ix, 1'h1, d);
    chk({31'h0, err}, 32'h0, "write refused");
  endtask

  task automatic rd(input logic [5:0] ix, input logic [7:0] e, input string m);
    apb(ix, 1'h0, 8'h00);
    chk({24'h0, q}, {24'h0, e}, m);
  endtask

  task automatic calm(input int n, input string m);
    int k;
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      k += int'(cpu.entry === 1'h1);
    end
    chk(k, 0, m);
  endtask

  task automatic take(input logic [11:0] vec, input string m);
    int n;
    int np;
    logic [7:0] sp0;
    n = 0;
    np = 0;
    @(negedge clk);
    while (cpu.entry !== 1'h1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk({20'h0, cpu.vec_addr}, {20'h0, vec}, m);
    sp0 = sp;
    n = 0;
    while (cpu.entry === 1'h1 && n < 9)
    begin
      np += int'(cpu.push === 1'h1);
      @(negedge clk);
      n++;
    end
    chk(n, 4, "entry length");
    chk(np, 2, "push cycles");
    chk({24'h0, sp0 - sp}, 32'h2, "stack down");
    n = 0;
    while (cpu.jump === 1'h1 && n < 9)
    begin
      @(negedge clk);
      n++;
    end
    chk(n, 2, "jump length");
  endtask

  task automatic leave();
    int n;
    int np;
    logic [7:0] sp0;
    n = 0;
    np = 0;
    sp0 = sp;
    @(posedge clk);
    reti_req <= 1'h1;
    @(posedge clk);
    reti_req <= 1'h0;
    @(negedge clk);
    while (cpu.ret === 1'h1 && n < 9)
    begin
      np += int'(cpu.pop === 1'h1);
      @(negedge clk);
      n++;
    end
    chk(n, 4, "return length");
    chk(np, 2, "pop cycles");
    chk({24'h0, sp - sp0}, 32'h2, "stack up");
  endtask

  task automatic t_regs();
    logic [5:0] ix [5];
    logic [7:0] wm [5];
    ix = '{ifmsc_pkg::IDX_MCU, ifmsc_pkg::IDX_TFLG, ifmsc_pkg::IDX_TMSK,
      ifmsc_pkg::IDX_XFLG, ifmsc_pkg::IDX_XMSK};
    wm = '{ifmsc_pkg::MCU_MASK, 8'h00, ifmsc_pkg::TMR_MASK, 8'h00,
      ifmsc_pkg::EXT_MASK};
    rd(ifmsc_pkg::IDX_GIE, 8'h00, "global enable reset");
    for (int i = 0; i < 5; i++)
    begin
      rd(ix[i], ifmsc_pkg::RST_VAL, "reset value");
      wr(ix[i], 8'hff);
      rd(ix[i], wm[i], "writable bits");
      wr(ix[i], 8'h00);
    end
    apb(6'h00, 1'h0, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk({24'h0, q}, 32'h0, "unmapped data");
    $display("test registers done");
  endtask

  task automatic t_sense();
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(ifmsc_pkg::IDX_MCU, {6'h0, c});
      wr(ifmsc_pkg::IDX_XFLG, 8'hc0);
      pin_a <= 1'h0;
      repeat (5) @(posedge clk);
      wr(ifmsc_pkg::IDX_XFLG, 8'h00);
      rd(ifmsc_pkg::IDX_XFLG, {1'h0, c == 2'h1 || c == 2'h2, 6'h0},
        "falling edge");
      wr(ifmsc_pkg::IDX_XFLG, 8'h40);
      pin_a <= 1'h1;
      repeat (5) @(posedge clk);
      rd(ifmsc_pkg::IDX_XFLG, {1'h0, c == 2'h1 || c == 2'h3, 6'h0},
        "rising edge");
    end
    $display("test sense codes done");
  endtask

  task automatic t_ext();
    wr(ifmsc_pkg::IDX_MCU, 8'h08);
    wr(ifmsc_pkg::IDX_XFLG, 8'hc0);
    wr(ifmsc_pkg::IDX_XMSK, 8'h80);
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    pin_b <= 1'h0;
    take(12'h002, "pin one vector");
    rd(ifmsc_pkg::IDX_XFLG, 8'h00, "vector clears flag");
    rd(ifmsc_pkg::IDX_GIE, 8'h00, "entry clears enable");
    pin_b <= 1'h1;
    leave();
    wr(ifmsc_pkg::IDX_XMSK, 8'h00);
    $display("test pin vector done");
  endtask

  task automatic t_prio();
    wr(ifmsc_pkg::IDX_TMSK, 8'h82);
    ilen <= 2'h2;
    tmr.t0_ovf <= 1'h1;
    tmr.t1_wrap <= 1'h1;
    @(posedge clk);
    tmr.t0_ovf <= 1'h0;
    tmr.t1_wrap <= 1'h0;
    rd(ifmsc_pkg::IDX_TFLG, 8'h82, "overflow flags");
    calm(20, "no entry without enable");
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    take(12'h005, "lowest vector first");
    rd(ifmsc_pkg::IDX_TFLG, 8'h02, "other stays pending");
    stall <= 1'h1;
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    leave();
    calm(10, "wait for one instruction");
    @(posedge clk);
    stall <= 1'h0;
    // First instruction end only leaves the post-return hold
    calm(5, "one instruction first");
    take(12'h006, "eight-bit overflow vector");
    leave();
    $display("test priority done");
  endtask

  task automatic t_timer();
    wr(ifmsc_pkg::IDX_TFLG, 8'hff);
    wr(ifmsc_pkg::IDX_CMP_LO, 8'h34);
    wr(ifmsc_pkg::IDX_CMP_HI, 8'h12);
    wr(ifmsc_pkg::IDX_TMSK, 8'h40);
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    tmr.t1_count <= 16'h1234;
    take(12'h004, "compare vector");
    leave();
    rd(ifmsc_pkg::IDX_TFLG, 8'h00, "standing match");
    wr(ifmsc_pkg::IDX_TMSK, 8'h08);
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    cap_pin <= 1'h1;
    take(12'h003, "capture vector");
    leave();
    rd(ifmsc_pkg::IDX_CAP_LO, 8'h34, "capture low");
    rd(ifmsc_pkg::IDX_CAP_HI, 8'h12, "capture high");
    cap_pin <= 1'h0;
    tmr <= {1'h0, 1'h1, 1'h1, 16'h0000, 1'h0};
    @(posedge clk);
    tmr.t1_down <= 1'h0;
    repeat (2) @(posedge clk);
    rd(ifmsc_pkg::IDX_TFLG, 8'h80, "turn at zero");
    $display("test timer events done");
  endtask

  task automatic t_level();
    wr(ifmsc_pkg::IDX_MCU, 8'h00);
    wr(ifmsc_pkg::IDX_XMSK, 8'h40);
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    pin_a <= 1'h0;
    take(12'h001, "low level vector");
    rd(ifmsc_pkg::IDX_XFLG, 8'h00, "level leaves flag");
    leave();
    wr(ifmsc_pkg::IDX_GIE, 8'h80);
    take(12'h001, "level still requests");
    leave();
    wr(ifmsc_pkg::IDX_XMSK, 8'h00);
    pin_a <= 1'h1;
    $display("test level mode done");
  endtask

  task automatic t_sleep();
    logic [7:0] mm [3];
    int k;
    mm = '{8'h10, 8'h30, 8'h20};
    for (int i = 0; i < 3; i++)
    begin
      wr(ifmsc_pkg::IDX_MCU, mm[i]);
      @(posedge clk);
      doze <= 1'h1;
      @(posedge clk);
      doze <= 1'h0;
      k = 0;
      repeat (4)
      begin
        @(negedge clk);
        k += int'(sleep_enter === 1'h1);
      end
      chk(k, {31'h0, mm[i][5]}, "sleep entries");
      chk({31'h0, sleep_deep}, {31'h0, mm[i][4]}, "sleep kind");
    end
    $display("test sleep done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(negedge clk)
  begin
    if (cpu.entry === 1'h1 && !ent_q)
      chk({31'h0, done_q}, 32'h1, "entry after instruction end");
    ent_q <= cpu.entry === 1'h1;
    done_q <= instr_done === 1'h1;
  end

  initial
  begin
    #200000;
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_sense();
    t_ext();
    t_prio();
    t_timer();
    t_level();
    t_sleep();
    tally_and_finish();
  end
endmodule
`default_nettype wire
